// file: verilog/uohsc_pkg.sv
package uohsc_pkg;

	// Clock rate and protocol times
	localparam int CLK_KHZ      = 125000;
	localparam int SE0_IDLE_MS  = 2;
	localparam int DP_PULSE_MS  = 5;
	localparam int SE0_IDLE_CYC = SE0_IDLE_MS * CLK_KHZ;
	localparam int DP_PULSE_CYC = DP_PULSE_MS * CLK_KHZ;
	localparam int CNT_W        = 20;

	// Own AXI4-Lite register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_LEN  = 4'h4;
	localparam logic [3:0] OFS_STAT = 4'h8;

	// Control register fields
	localparam int C_GO_OUT = 0;
	localparam int C_GO_SRP = 1;
	localparam int C_GO_HNP = 2;
	localparam int C_GO_END = 3;
	localparam int C_LOW_SPEED_SELECT   = 4;
	localparam int C_RETRY  = 5;
	localparam int C_EP_LSB = 8;
	localparam int C_AD_LSB = 16;

	// Status register fields
	localparam int S_BUSY   = 0;
	localparam int S_DONE   = 1;
	localparam int S_STALL  = 2;
	localparam int S_DETACH = 3;
	localparam int S_SESEND = 4;
	localparam int S_HOST   = 5;
	localparam int S_PIDLSB = 8;

	// Device register indices on the device port
	localparam logic [7:0] DEV_EP0    = 8'h00;
	localparam logic [7:0] DEV_ADDR   = 8'h01;
	localparam logic [7:0] DEV_TOK    = 8'h02;
	localparam logic [7:0] DEV_USBIR  = 8'h03;
	localparam logic [7:0] DEV_OTGIR  = 8'h04;
	localparam logic [7:0] DEV_OTGCON = 8'h05;
	localparam logic [7:0] DEV_CNFG2  = 8'h06;
	localparam logic [7:0] DEV_BDSTAT = 8'h07;
	localparam logic [7:0] DEV_BDCNT  = 8'h08;
	localparam logic [7:0] DEV_CTL    = 8'h09;

	// Device register values and bit positions
	localparam logic [7:0] EP0_HSK_TXRX = 8'h1d;
	localparam int EP0_LOW_SPEED_SELECT     = 7;
	localparam int EP0_RETRY_DISABLE = 6;
	localparam int IR_DETACH    = 0;
	localparam int IR_TRN       = 3;
	localparam int IR_STALL     = 7;
	localparam int IR_ATTACH    = 6;
	localparam int OTG_SESEND   = 2;
	localparam int OTG_SESVD    = 3;
	localparam logic [7:0] OTGCON_DPPU = 8'h80;
	localparam logic [7:0] OTGCON_DMPU = 8'h40;
	localparam logic [7:0] OTGCON_VDIS = 8'h01;
	localparam logic [7:0] CNFG2_VPUL  = 8'h10;
	localparam logic [7:0] CTL_BUSRST  = 8'h10;
	localparam logic [3:0] PID_OUT     = 4'h1;
	localparam int BD_PID_LSB   = 2;
	localparam logic [6:0] BD_MAX = 7'h40;

	typedef enum {
		ST_IDLE, ST_EPCFG, ST_BDCNT, ST_ADDR, ST_TOKEN, ST_POLL, ST_PID,
		ST_CLR, ST_CHKEND, ST_DISCH, ST_SE0, ST_DPON, ST_DPWAIT, ST_DPOFF,
		ST_VPON, ST_SESVD, ST_VPOFF, ST_RECON, ST_HDROP, ST_HATT, ST_HRST,
		ST_HEND
	} uohsc_state_t;

	// One access toward the device register port
	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] data;
	} uohsc_devcmd_t;

endpackage

// file: verilog/uohsc_ctrl.sv
// Function
// [R1] Endpoint-zero control is written 1Dh for handshaked transmit and receive.
// [R2] Bit 7 picks low speed; bit 6 clear lets NAKs retry forever.
// [R3] Descriptor payload is refused above 64 bytes before an OUT transfer.
// [R4] The 7-bit target address goes to the device address register.
// [R5] Writing an OUT token and endpoint starts the transfer.
// [R6] Transfer ends when the token-complete flag sets after descriptor release.
// [R7] With retry disabled, the handshake or 0Fh error sits in descriptor PID.
// [R8] SE0 beyond 2.5 us shows as detach flag bit 0.
// [R9] After stall, the packet is dropped and software clears the target.
// [R10] Speed and pull-up settings change only while the controller is idle.
// [R11] Session request and host negotiation start only at full speed.
// [R12] Session request waits for session end and 2 ms of both lines low.
// [R13] Session end shows as bit 2 of the OTG flag register.
// [R14] OTG control bits 7 and 6 connect D+ and D- pull-ups.
// [R15] OTG control bit 0 discharges VBUS through a resistor.
// [R16] Session request raises the D+ pull-up for 5 to 10 ms.
// [R17] After the D+ pulse, configuration two bit 4 pulses VBUS.
// [R18] The A-device sees the request by attach or session-valid, then resets.
// [R19] VBUS is ignored while pulsing; reconnect once session-valid sets.
// [R20] HNP host request clears both pull-ups during suspend.
// [R21] On attach the B-device takes host role and drives reset first.
// [R22] Finishing as host, the B-device stops and enables its D+ pull-up.
// [R23] Device flags stay set until cleared and gate an interrupt request; this controller has no interrupt output.
module uohsc_ctrl
	import uohsc_pkg::*;
#(
	parameter int SE0_CYC   = SE0_IDLE_CYC,
	parameter int PULSE_CYC = DP_PULSE_CYC
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic [3:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [3:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output uohsc_devcmd_t      devCmd,
	output logic               devCmdValid,
	input  wire logic          devAck,
	input  wire logic [7:0]    devRdData,
	input  wire logic          dPlusPin,
	input  wire logic          dMinusPin
);

	generate
		if (SE0_CYC < 1 || SE0_CYC >= (1 << CNT_W) ||
			PULSE_CYC < 1 || PULSE_CYC >= (1 << CNT_W)) begin : g_bad
			$error("uohsc_ctrl: count parameter out of range");
		end
	endgenerate

	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	localparam logic [CNT_W-1:0] SE0_LAST   = CNT_W'(SE0_CYC - 1);
	localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);

	uohsc_state_t state;
	uohsc_state_t next_state;
	logic [CNT_W-1:0] cnt;
	logic [1:0]  dpSync;
	logic [1:0]  dmSync;
	logic        lowSpeed;
	logic        retry_disable;
	logic [3:0]  epNum;
	logic [6:0]  tgtAddr;
	logic [6:0]  byteCnt;
	logic        goOut;
	logic        goSrp;
	logic        goHnp;
	logic        goEnd;
	logic        stDone;
	logic        stStall;
	logic        stDetach;
	logic        stSesEnd;
	logic        hostRole;
	logic [3:0]  hskPid;
	logic        busy;
	logic        wrFire;
	logic        isAcc;
	logic        stepDone;
	uohsc_devcmd_t acc;

	function automatic logic mapped(input logic [3:0] a);
		return a == OFS_CTRL || a == OFS_LEN || a == OFS_STAT;
	endfunction

	function automatic logic isAccess(input uohsc_state_t s);
		return !(s == ST_IDLE || s == ST_SE0 || s == ST_DPWAIT);
	endfunction

	assign busy     = state != ST_IDLE;
	assign wrFire   = s_axi_awready && s_axi_wready;
	assign isAcc    = isAccess(state);
	assign stepDone = devCmdValid && devAck;

	// Line synchronisers for the SE0 idle check
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dpSync <= 2'h0;
			dmSync <= 2'h0;
		end else begin
			dpSync <= {dpSync[0], dPlusPin};
			dmSync <= {dmSync[0], dMinusPin};
		end
	end

	// AXI write channel: take address and data together
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OK;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
				!s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (wrFire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (!mapped(s_axi_awaddr) ||
					(s_axi_awaddr == OFS_LEN &&
					s_axi_wdata[6:0] > BD_MAX)) ? RESP_ERR : RESP_OK; // R3
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Configuration and command pulses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lowSpeed <= 1'b0;
			retry_disable <= 1'b0;
			epNum    <= 4'h0;
			tgtAddr  <= 7'h00;
			byteCnt  <= 7'h00;
			goOut    <= 1'b0;
			goSrp    <= 1'b0;
			goHnp    <= 1'b0;
			goEnd    <= 1'b0;
		end else begin
			goOut <= 1'b0;
			goSrp <= 1'b0;
			goHnp <= 1'b0;
			goEnd <= 1'b0;
			if (wrFire && !busy && s_axi_wstrb[0]) begin // R10
				if (s_axi_awaddr == OFS_CTRL) begin
					lowSpeed <= s_axi_wdata[C_LOW_SPEED_SELECT];
					retry_disable <= s_axi_wdata[C_RETRY];
					epNum    <= s_axi_wdata[C_EP_LSB +: 4];
					tgtAddr  <= s_axi_wdata[C_AD_LSB +: 7];
					goOut    <= s_axi_wdata[C_GO_OUT];
					goSrp    <= s_axi_wdata[C_GO_SRP] &
						!s_axi_wdata[C_LOW_SPEED_SELECT]; // R11
					goHnp    <= s_axi_wdata[C_GO_HNP] &
						!s_axi_wdata[C_LOW_SPEED_SELECT]; // R11
					goEnd    <= s_axi_wdata[C_GO_END];
				end else if (s_axi_awaddr == OFS_LEN &&
					s_axi_wdata[6:0] <= BD_MAX) begin
					byteCnt <= s_axi_wdata[6:0]; // R3
				end
			end
		end
	end

	// Access toward the device for each state
	always_comb begin
		acc = '{we: 1'b1, addr: DEV_EP0, data: 8'h00};
		case (state)
			ST_EPCFG: acc.data = EP0_HSK_TXRX | // R1
				({7'h00, lowSpeed} << EP0_LOW_SPEED_SELECT) |
				({7'h00, retry_disable} << EP0_RETRY_DISABLE); // R2
			ST_BDCNT: acc = '{1'b1, DEV_BDCNT, {1'b0, byteCnt}}; // R3
			ST_ADDR: acc = '{1'b1, DEV_ADDR, {1'b0, tgtAddr}}; // R4
			ST_TOKEN: acc = '{1'b1, DEV_TOK, {PID_OUT, epNum}}; // R5
			ST_POLL: acc = '{1'b0, DEV_USBIR, 8'h00};
			ST_PID: acc = '{1'b0, DEV_BDSTAT, 8'h00};
			ST_CLR: acc = '{1'b1, DEV_USBIR,
				8'h01 << IR_TRN | 8'h01 << IR_STALL};
			ST_CHKEND: acc = '{1'b0, DEV_OTGIR, 8'h00};
			ST_DISCH: acc = '{1'b1, DEV_OTGCON, OTGCON_VDIS}; // R15
			ST_DPON: acc = '{1'b1, DEV_OTGCON, OTGCON_DPPU}; // R16
			ST_DPOFF: acc = '{1'b1, DEV_OTGCON, 8'h00}; // R14
			ST_VPON: acc = '{1'b1, DEV_CNFG2, CNFG2_VPUL}; // R17
			ST_SESVD: acc = '{1'b0, DEV_OTGIR, 8'h00};
			ST_VPOFF: acc = '{1'b1, DEV_CNFG2, 8'h00};
			ST_RECON: acc = '{1'b1, DEV_OTGCON, OTGCON_DPPU}; // R19
			ST_HDROP: acc = '{1'b1, DEV_OTGCON, 8'h00}; // R20
			ST_HATT: acc = '{1'b0, DEV_USBIR, 8'h00};
			ST_HRST: acc = '{1'b1, DEV_CTL, CTL_BUSRST}; // R18 R21
			ST_HEND: acc = '{1'b1, DEV_OTGCON, OTGCON_DPPU}; // R22
			default: acc.we = 1'b0;
		endcase
	end

	// Sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (goOut) next_state = ST_EPCFG;
				else if (goSrp) next_state = ST_CHKEND;
				else if (goHnp) next_state = ST_HDROP;
				else if (goEnd) next_state = ST_HEND;
			end
			ST_EPCFG: next_state = ST_BDCNT;
			ST_BDCNT: next_state = ST_ADDR;
			ST_ADDR: next_state = ST_TOKEN;
			ST_TOKEN: next_state = ST_POLL;
			ST_POLL: begin
				if (devRdData[IR_DETACH]) next_state = ST_IDLE; // R8
				else if (devRdData[IR_STALL]) next_state = ST_CLR; // R9
				else if (devRdData[IR_TRN]) next_state = ST_PID; // R6
			end
			ST_PID: next_state = ST_CLR;
			ST_CHKEND: if (devRdData[OTG_SESEND]) next_state = ST_DISCH; // R13
			ST_DISCH: next_state = ST_SE0;
			ST_SE0: if (!dpSync[1] && !dmSync[1] && cnt == SE0_LAST)
				next_state = ST_DPON; // R12
			ST_DPON: next_state = ST_DPWAIT;
			ST_DPWAIT: if (cnt == PULSE_LAST) next_state = ST_DPOFF; // R16
			ST_DPOFF: next_state = ST_VPON;
			ST_VPON: next_state = ST_SESVD;
			ST_SESVD: if (devRdData[OTG_SESVD]) next_state = ST_VPOFF; // R19
			ST_VPOFF: next_state = ST_RECON;
			ST_HDROP: next_state = ST_HATT;
			ST_HATT: if (devRdData[IR_ATTACH]) next_state = ST_HRST; // R21
			default: next_state = ST_IDLE;
		endcase
	end

	// Sequencer state: access states move on the device answer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) state <= ST_IDLE;
		else if (!isAcc || stepDone) state <= next_state;
	end

	// Device port request, held until answered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			devCmdValid <= 1'b0;
			devCmd      <= '0;
		end else if (stepDone) begin
			devCmdValid <= 1'b0;
		end else if (isAcc && !devCmdValid) begin
			devCmdValid <= 1'b1;
			devCmd      <= acc;
		end
	end

	// Idle and pulse timer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) cnt <= '0;
		else if ((state == ST_SE0 && (dpSync[1] || dmSync[1])) ||
			(state != ST_SE0 && state != ST_DPWAIT) || next_state != state)
			cnt <= '0; // R12
		else cnt <= cnt + 1'b1;
	end

	// Status flags: hardware set wins over write-one clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stDone   <= 1'b0;
			stStall  <= 1'b0;
			stDetach <= 1'b0;
			stSesEnd <= 1'b0;
			hostRole <= 1'b0;
			hskPid   <= 4'h0;
		end else begin
			if (wrFire && s_axi_awaddr == OFS_STAT && s_axi_wstrb[0]) begin
				stDone   <= stDone & !s_axi_wdata[S_DONE]; // R23
				stStall  <= stStall & !s_axi_wdata[S_STALL];
				stDetach <= stDetach & !s_axi_wdata[S_DETACH];
				stSesEnd <= stSesEnd & !s_axi_wdata[S_SESEND];
			end
			if (stepDone) begin
				if (state == ST_CLR) stDone <= 1'b1; // R6
				if (state == ST_POLL && devRdData[IR_DETACH])
					stDetach <= 1'b1; // R8
				if (state == ST_POLL && !devRdData[IR_DETACH] &&
					devRdData[IR_STALL]) stStall <= 1'b1; // R9
				if (state == ST_PID)
					hskPid <= devRdData[BD_PID_LSB +: 4]; // R7
				if (state == ST_CHKEND && devRdData[OTG_SESEND])
					stSesEnd <= 1'b1; // R13
				if (state == ST_HRST) hostRole <= 1'b1; // R21
				if (state == ST_HEND) hostRole <= 1'b0; // R22
			end
		end
	end

	// AXI read channel
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OK;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
				case (s_axi_araddr)
					OFS_CTRL: s_axi_rdata <= {9'h0, tgtAddr, 4'h0, epNum,
						2'h0, retry_disable, lowSpeed, 4'h0};
					OFS_LEN: s_axi_rdata <= {25'h0, byteCnt};
					OFS_STAT: s_axi_rdata <= {20'h0, hskPid, 2'h0, hostRole,
						stSesEnd, stDetach, stStall, stDone, busy};
					default: s_axi_rdata <= 32'h0;
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // uohsc_ctrl

// file: dv/uohsc_properties.sv
module uohsc_properties
	import uohsc_pkg::*;
(
	input wire logic          clk,
	input wire logic          rst_n,
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wready,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready,
	input wire logic [31:0]   s_axi_rdata,
	input wire uohsc_devcmd_t devCmd,
	input wire logic          devCmdValid,
	input wire logic          devAck
);
	timeunit 1ns;
	timeprecision 1ps;
	// Device write in progress
	logic devWr;
	assign devWr = devCmdValid && devCmd.we;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Bus handshakes and answers
	property p_awpair;
		s_axi_awready |-> s_axi_wready ##1 !s_axi_awready;
	endproperty
	a_awpair: assert property (p_awpair) else $error("ready pulse wrong");
	property p_bans;
		s_axi_awready && s_axi_awvalid |=> s_axi_bvalid;
	endproperty
	a_bans: assert property (p_bans) else $error("write answer late");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rans;
		s_axi_arready && s_axi_arvalid |=> s_axi_rvalid;
	endproperty
	a_rans: assert property (p_rans) else $error("read answer late");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data moved");
	// Device port requests
	property p_cmdhold;
		devCmdValid && !devAck |=> devCmdValid && $stable(devCmd);
	endproperty
	a_cmdhold: assert property (p_cmdhold) else $error("device request moved");
	property p_cmddrop;
		devCmdValid && devAck |=> !devCmdValid;
	endproperty
	a_cmddrop: assert property (p_cmddrop) else $error("request not dropped");
	property p_ep0;
		devWr && devCmd.addr == DEV_EP0 |-> devCmd.data[5:0] == 6'h1d;
	endproperty
	a_ep0: assert property (p_ep0)
		else $error("endpoint value wrong");
	property p_tok;
		devWr && devCmd.addr == DEV_TOK |-> devCmd.data[7:4] == PID_OUT;
	endproperty
	a_tok: assert property (p_tok)
		else $error("token not OUT");
	property p_addr;
		devWr && devCmd.addr == DEV_ADDR |-> !devCmd.data[7];
	endproperty
	a_addr: assert property (p_addr)
		else $error("address too wide");
	c_tok: cover property (devAck && devWr && devCmd.addr == DEV_TOK);
	c_rst: cover property (devAck && devWr && devCmd.addr == DEV_CTL);
	c_vp: cover property (devAck && devWr && devCmd.addr == DEV_CNFG2);
endmodule // uohsc_properties

bind uohsc_ctrl uohsc_properties u_props (
	.clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .devCmd, .devCmdValid,
	.devAck
);

// file: dv/uohsc_dev_model.sv
module uohsc_dev_model
	import uohsc_pkg::*;
#(
	parameter logic [3:0] HSK_CODE = 4'h2
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire uohsc_devcmd_t devCmd,
	input  wire logic          devCmdValid,
	input  wire logic [1:0]    outcome,
	input  wire logic [1:0]    lat,
	input  wire logic          vbusOk,
	output logic               devAck,
	output logic [7:0]         devRdData
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] regs [0:9];
	logic [1:0] waitCnt;
	logic [3:0] evtCnt;
	logic [2:0] evtKind;
	logic       sawDisch;
	logic       take;
	int         nAcc, dpCnt, pulseLen;

	// Access accepted this cycle
	assign take = devCmdValid && !devAck && waitCnt == lat;

	// Register port, flags and bus events
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regs <= '{default: 8'h00};
			{devAck, sawDisch, waitCnt, evtCnt, evtKind} <= '0;
			devRdData <= 8'h00;
			{nAcc, dpCnt, pulseLen} <= '0;
		end else begin
			devAck <= 1'b0;
			devRdData <= ~devRdData; // Wanders outside answers
			if (!vbusOk)
				regs[4][OTG_SESEND] <= 1'b1;
			if (regs[5][7])
				dpCnt <= dpCnt + 1;
			if (evtCnt != 4'h0)
				evtCnt <= evtCnt - 4'h1;
			if (evtCnt == 4'h1)
				case (evtKind)
					3'd0: begin
						regs[3][IR_TRN] <= 1'b1;
						regs[7][5:2] <= HSK_CODE;
					end
					3'd1: regs[3][IR_STALL] <= 1'b1;
					3'd2: regs[3][IR_DETACH] <= 1'b1;
					3'd4: regs[4][OTG_SESVD] <= 1'b1;
					default: regs[3][IR_ATTACH] <= 1'b1;
				endcase
			if (devCmdValid && !devAck)
				waitCnt <= waitCnt + 2'd1;
			if (take) begin
				waitCnt <= 2'd0;
				devAck <= 1'b1;
				nAcc <= nAcc + 1;
				devRdData <= regs[devCmd.addr[3:0]];
			end
			if (take && devCmd.we) begin
				regs[devCmd.addr[3:0]] <= devCmd.data;
				if (devCmd.addr == DEV_USBIR)
					regs[3] <= regs[3] & ~devCmd.data;
				if (devCmd.addr == DEV_TOK) begin
					evtCnt <= 4'd8;
					evtKind <= {1'b0, outcome};
				end
				if (devCmd.addr == DEV_CNFG2 && devCmd.data[4]) begin
					evtCnt <= 4'd8;
					evtKind <= 3'd4;
				end
				if (devCmd.addr == DEV_OTGCON) begin
					if (devCmd.data == OTGCON_VDIS)
						sawDisch <= 1'b1;
					if (!devCmd.data[7] && regs[5][7]) begin
						pulseLen <= dpCnt;
						dpCnt <= 0;
					end
					if (devCmd.data == 8'h00 && vbusOk) begin
						evtCnt <= 4'd8;
						evtKind <= 3'd5;
					end
				end
			end
		end
	end
endmodule // uohsc_dev_model

// file: dv/tb.sv
module tb
	import uohsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, devCmdValid;
	logic devAck, dPlusPin, dMinusPin, vbusOk;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, outcome, lat, rs;
	logic [7:0] devRdData;
	uohsc_devcmd_t devCmd;
	int badCount, nChecks, cyc;

	uohsc_ctrl #(.SE0_CYC(8), .PULSE_CYC(16)) DUT (
		.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .devCmd, .devCmdValid, .devAck,
		.devRdData, .dPlusPin, .dMinusPin
	);
	uohsc_dev_model mdl (
		.clk, .rst_n, .devCmd, .devCmdValid, .outcome, .lat, .vbusOk,
		.devAck, .devRdData
	);

	// Clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Cycle ceiling against hangs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			badCount++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] got, exp, input string m);
		nChecks++;
		if (got !== exp) begin
			badCount++;
			$display("mismatch t=%0t %s", $time, m);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rdr(input logic [3:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic idle();
		repeat (4) @(posedge clk);
		do rdr(OFS_STAT); while (rd[S_BUSY] !== 1'b0);
	endtask

	task automatic tRegs();
		rdr(OFS_STAT);
		chk(rd, 0, "status reset");
		rdr(4'hc);
		chk({rd[29:0], rs}, 2, "unmapped read");
		wr(4'hc, 0);
		chk(rs, 2, "unmapped write");
		wr(OFS_LEN, 32'h41);
		chk(rs, 2, "length over");
		wr(OFS_LEN, 32'h40);
		rdr(OFS_LEN);
		chk(rd, 32'h40, "length");
		$display("test regs done");
	endtask

	task automatic tOut(input logic [1:0] oc, input logic ls, logic [31:0] m);
		outcome <= oc;
		wr(OFS_CTRL, {9'h0, 7'h55, 4'h0, 4'h3, 2'b00, ls, ls, 4'h1});
		wr(OFS_LEN, 32'h10);
		idle();
		chk(rd & m, m, "out status");
		chk(mdl.regs[0], {ls, ls, 6'h1d}, "ep0");
		chk(mdl.regs[1], 8'h55, "address");
		chk(mdl.regs[2], {PID_OUT, 4'h3}, "token");
		chk(mdl.regs[8], 8'h40, "count");
		chk(mdl.regs[3] & 8'h88, 0, "flags left");
		rdr(OFS_LEN);
		chk(rd, 32'h40, "busy write");
		wr(OFS_STAT, 32'h1e);
		$display("test out done");
	endtask

	task automatic tLow();
		int n;
		n = mdl.nAcc;
		wr(OFS_CTRL, 32'h12);
		idle();
		chk(mdl.nAcc, n, "low speed request");
		$display("test low done");
	endtask

	task automatic tSrp();
		{vbusOk, dPlusPin, dMinusPin} <= 3'b000;
		wr(OFS_CTRL, 32'h2);
		idle();
		chk(mdl.sawDisch, 1, "discharge");
		chk(mdl.pulseLen >= 16 && mdl.pulseLen <= 32, 1, "pulse");
		chk(mdl.regs[6], 0, "vbus pulse");
		chk(mdl.regs[5], OTGCON_DPPU, "reconnect");
		chk(rd[S_SESEND], 1, "session end");
		{vbusOk, dPlusPin} <= 2'b11;
		$display("test srp done");
	endtask

	task automatic tHnp();
		lat <= 2'd3;
		wr(OFS_CTRL, 32'h4);
		do rdr(OFS_STAT); while (rd[S_HOST] !== 1'b1);
		chk(mdl.regs[5], 0, "pullups off");
		chk(mdl.regs[9], CTL_BUSRST, "bus reset");
		wr(OFS_CTRL, 32'h8);
		do rdr(OFS_STAT); while (rd[S_HOST] !== 1'b0);
		chk(mdl.regs[5], OTGCON_DPPU, "host end");
		$display("test hnp done");
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, rst_n, dMinusPin} = '0;
		{outcome, lat, badCount, nChecks} = '0;
		{dPlusPin, vbusOk} = 2'b11;
		s_axi_wstrb = 4'hf;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		tRegs();
		tOut(2'd0, 1'b1, 32'h202);
		tOut(2'd1, 1'b0, 32'h4);
		tOut(2'd2, 1'b1, 32'h8);
		tLow();
		tSrp();
		tHnp();
		conclude();
	end
endmodule // tb
